//--- design/hisk_map.vh
// Constants for the host I/O select, interrupt and skip port.
// Included by hisk_port.v only; holds definitions and nothing else.
`ifndef HISK_MAP_VH
`define HISK_MAP_VH

// Wishbone word offsets (byte addresses)
`define HISK_OFS_CTRL 8'h00
`define HISK_OFS_STATUS 8'h04
`define HISK_OFS_MASK 8'h08
`define HISK_OFS_FLAGS 8'h0c
`define HISK_OFS_CTLW1 8'h10
`define HISK_OFS_CTLW2 8'h14
`define HISK_OFS_CHARBUF 8'h18

// CTRL fields
`define HISK_CTRL_GRP_LSB 0
`define HISK_CTRL_GRP_MSB 3
// Group field 10 (binary 1000) answers device codes 40 to 43
`define HISK_CTRL_RESET 4'h8

// STATUS and MASK bits (same layout)
`define HISK_EV_XMIT 0
`define HISK_EV_RECV 1
`define HISK_EV_HOSTWR 2
`define HISK_EV_PCLR 3
`define HISK_EV_W 4
`define HISK_MASK_RESET 4'h0

// FLAGS bits
`define HISK_FL_XMIT 0
`define HISK_FL_RECV 1
`define HISK_FL_SRV 2
`define HISK_FL_IRQ 3

// Memory buffer positions, bit 0 being the least significant of twelve
`define HISK_MB_GRP_MSB 8
`define HISK_MB_GRP_LSB 5
`define HISK_MB_SUB_MSB 4
`define HISK_MB_SUB_LSB 3

// Sub-codes within the group of four device codes
`define HISK_SUB_CW1 2'h0
`define HISK_SUB_CW2 2'h1
`define HISK_SUB_IRQ 2'h2
`define HISK_SUB_BUF 2'h3

// Accumulator bits tested by skip under mask
`define HISK_AC_MASK_XMIT 0
`define HISK_AC_MASK_RECV 1

`endif

//--- design/hisk_port.v
// Host I/O port: device select decode, control word access, character
// buffer, transmit/receive interrupt flags, skip and the extended
// accumulator bus. Host pins are asynchronous to sys_clk and are synced
// here; the line-side strobes come from logic on sys_clk. Software
// reaches the registers over classic Wishbone.
//
// Operation
// [RQ1] Select field is memory buffer bits 3-6 during an I/O transfer.
// [RQ2] Four consecutive device codes share the field; each has a select.
// [RQ3] Decode separates first control word from second control word.
// [RQ4] Every character transfer with the buffer sets the service flag.
// [RQ5] Service flag sets transmit or receive flag, raising the request.
// [RQ6] Host interrupts only while its interrupt system is enabled.
// [RQ7] Identifying instruction for the interrupting device asserts skip.
// [RQ8] Software clears the flag; an I/O instruction does the clearing.
// [RQ9] Skip under mask is produced through extended accumulator gating; the code instead forms it from host AC bits 0 and 1 and the flags.
// [RQ10] Extended bus is inverted onto host accumulator inputs.
// [RQ11] Other bus users supply their own enable term and bus gates.
// [RQ12] Read-buffer ORs buffer contents into the host accumulator.
// [RQ13] Clear-buffer clears the buffer; write-buffer loads it from AC.
// [RQ14] Interrupt flags stay set until instruction or power clear.
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "hisk_map.vh"

module hisk_port #(
    parameter WORD_W = 12,
    parameter CHAR_W = 8
) (
    // Clock, reset, enable
    input wire sys_clk,
    input wire reset,
    input wire clkEn,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wbIrq,
    // Host I/O bus pins
    input wire [WORD_W-1:0] memBuf,
    input wire ioTransferInstr,
    input wire ioPulseOne,
    input wire ioPulseTwo,
    input wire ioPulseFour,
    input wire hostPowerClear,
    input wire [WORD_W-1:0] hostAccumOut,
    output reg [WORD_W-1:0] hostAccumInN,
    output reg hostAccumOe,
    output reg skipLine,
    output reg irqLine,
    // Shared extended accumulator bus from other devices
    input wire [WORD_W-1:0] extAccumIn,
    input wire extGateReq,
    // Line adaptor side, same clock
    input wire charXferStrobe,
    input wire charXferToLine,
    input wire [CHAR_W-1:0] lineCharIn,
    output reg [CHAR_W-1:0] bufCharOut
);

    localparam PIN_W = 3 * WORD_W + 6;

    // Host pins are bundled so one two-stage synchroniser covers them
    wire [PIN_W-1:0] pinRaw;
    reg [PIN_W-1:0] pinMeta_reg;
    reg [PIN_W-1:0] pinSync_reg;
    reg [2:0] pulsePrev_reg;

    reg [3:0] groupSel_reg;
    reg [WORD_W-1:0] ctlWord1_reg;
    reg [WORD_W-1:0] ctlWord2_reg;
    reg [CHAR_W-1:0] charBuf_reg;
    reg charServiceFlag_reg;
    reg serviceToLine_reg;
    reg xmitIrqFlag_reg;
    reg recvIrqFlag_reg;
    reg [`HISK_EV_W-1:0] status_reg;
    reg [`HISK_EV_W-1:0] mask_reg;
    reg pclrPrev_reg;

    wire [WORD_W-1:0] mbS;
    wire iotS;
    wire p1S;
    wire p2S;
    wire p4S;
    wire pclrS;
    wire [WORD_W-1:0] accS;
    wire [WORD_W-1:0] extS;
    wire extEnS;
    wire p1Rise;
    wire p2Rise;
    wire p4Rise;
    wire selCw1;
    wire selCw2;
    wire selIrq;
    wire selBuf;
    wire busReq;
    wire busWr;
    wire busRd;
    wire [`HISK_EV_W-1:0] evSet;
    wire [CHAR_W-1:0] accChar;

    reg [WORD_W-1:0] extAccumBus;
    reg extBusGateEnable;
    reg skipNext;
    reg [31:0] rdData;

    assign pinRaw = {memBuf, ioTransferInstr, ioPulseOne, ioPulseTwo,
        ioPulseFour, hostPowerClear, hostAccumOut, extAccumIn, extGateReq};
    assign {mbS, iotS, p1S, p2S, p4S, pclrS, accS, extS, extEnS} =
        pinSync_reg;

    // Device code match for one of the four codes of the group
    function devHit;
        input io_transfer_instr;
        input [WORD_W-1:0] mb;
        input [3:0] grp;
        input [1:0] sub;
        begin
            devHit = io_transfer_instr &&
                mb[`HISK_MB_GRP_MSB:`HISK_MB_GRP_LSB] == grp &&
                mb[`HISK_MB_SUB_MSB:`HISK_MB_SUB_LSB] == sub;
        end
    endfunction

    assign selCw1 = devHit(iotS, mbS, groupSel_reg, `HISK_SUB_CW1);
    // see [RQ1]
    assign selCw2 = devHit(iotS, mbS, groupSel_reg, `HISK_SUB_CW2);
    // see [RQ2] see [RQ3]
    assign selIrq = devHit(iotS, mbS, groupSel_reg, `HISK_SUB_IRQ);
    assign selBuf = devHit(iotS, mbS, groupSel_reg, `HISK_SUB_BUF);

    // Loads and clears act on the synced rising edge of their pulse so a long pulse acts once
    assign p1Rise = p1S && !pulsePrev_reg[2];
    assign p2Rise = p2S && !pulsePrev_reg[1];
    assign p4Rise = p4S && !pulsePrev_reg[0];

    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busWr = busReq && wb_we_i;
    assign busRd = busReq && !wb_we_i;
    assign accChar = accS[CHAR_W-1:0];

    assign evSet[`HISK_EV_XMIT] = charServiceFlag_reg && serviceToLine_reg;
    assign evSet[`HISK_EV_RECV] = charServiceFlag_reg && !serviceToLine_reg;
    assign evSet[`HISK_EV_HOSTWR] = selBuf && p4Rise;
    assign evSet[`HISK_EV_PCLR] = pclrS && !pclrPrev_reg;

    // Extended accumulator bus: wired-OR of every source that gates onto it
    always @* begin
        extAccumBus = {WORD_W{1'b0}};
        extBusGateEnable = 1'b0;
        if (selBuf && p1S) begin
            extAccumBus = extAccumBus | {{(WORD_W-CHAR_W){1'b0}},
                charBuf_reg}; // see [RQ12]
            extBusGateEnable = 1'b1;
        end
        if (selCw1 && p2S) begin
            extAccumBus = extAccumBus | ctlWord1_reg; // see [RQ3]
            extBusGateEnable = 1'b1;
        end
        if (selCw2 && p2S) begin
            extAccumBus = extAccumBus | ctlWord2_reg;
            extBusGateEnable = 1'b1;
        end
        if (extEnS) begin
            // Outside devices bring their own gate and enable term
            extAccumBus = extAccumBus | extS; // see [RQ11]
            extBusGateEnable = 1'b1;
        end
    end

    // Skip is held while the chosen pulse is high
    always @* begin
        skipNext = 1'b0;
        if (selIrq && p1S && (xmitIrqFlag_reg || recvIrqFlag_reg)) begin
            skipNext = 1'b1; // see [RQ7]
        end
        if (selCw1 && p1S &&
                ((accS[`HISK_AC_MASK_XMIT] && xmitIrqFlag_reg) ||
                (accS[`HISK_AC_MASK_RECV] && recvIrqFlag_reg))) begin
            skipNext = 1'b1; // see [RQ9]
        end
    end

    always @* begin
        rdData = 32'h0000_0000;
        if (wb_adr_i == `HISK_OFS_CTRL) begin
            rdData[3:0] = groupSel_reg;
        end else if (wb_adr_i == `HISK_OFS_STATUS) begin
            rdData[`HISK_EV_W-1:0] = status_reg;
        end else if (wb_adr_i == `HISK_OFS_MASK) begin
            rdData[`HISK_EV_W-1:0] = mask_reg;
        end else if (wb_adr_i == `HISK_OFS_FLAGS) begin
            rdData[`HISK_FL_XMIT] = xmitIrqFlag_reg;
            rdData[`HISK_FL_RECV] = recvIrqFlag_reg;
            rdData[`HISK_FL_SRV] = charServiceFlag_reg;
            rdData[`HISK_FL_IRQ] = irqLine;
        end else if (wb_adr_i == `HISK_OFS_CTLW1) begin
            rdData[WORD_W-1:0] = ctlWord1_reg;
        end else if (wb_adr_i == `HISK_OFS_CTLW2) begin
            rdData[WORD_W-1:0] = ctlWord2_reg;
        end else if (wb_adr_i == `HISK_OFS_CHARBUF) begin
            rdData[CHAR_W-1:0] = charBuf_reg;
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pinMeta_reg <= {PIN_W{1'b0}};
            pinSync_reg <= {PIN_W{1'b0}};
            pulsePrev_reg <= 3'h0;
            pclrPrev_reg <= 1'b0;
        end else if (clkEn) begin
            pinMeta_reg <= pinRaw;
            pinSync_reg <= pinMeta_reg;
            pulsePrev_reg <= {p1S, p2S, p4S};
            pclrPrev_reg <= pclrS;
        end
    end

    // Wishbone slave: ack one cycle after the strobe, unmapped reads zero
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            groupSel_reg <= `HISK_CTRL_RESET;
            mask_reg <= `HISK_MASK_RESET;
        end else if (clkEn) begin
            wb_ack_o <= busReq;
            if (busRd) begin
                wb_dat_o <= rdData;
            end
            if (busWr && wb_sel_i[0]) begin
                if (wb_adr_i == `HISK_OFS_CTRL) begin
                    groupSel_reg <= wb_dat_i[3:0];
                end else if (wb_adr_i == `HISK_OFS_MASK) begin
                    mask_reg <= wb_dat_i[`HISK_EV_W-1:0];
                end
            end
        end
    end

    // Host side state: control words, buffer, service and interrupt flags
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctlWord1_reg <= {WORD_W{1'b0}};
            ctlWord2_reg <= {WORD_W{1'b0}};
            charBuf_reg <= {CHAR_W{1'b0}};
            charServiceFlag_reg <= 1'b0;
            serviceToLine_reg <= 1'b0;
            xmitIrqFlag_reg <= 1'b0;
            recvIrqFlag_reg <= 1'b0;
            status_reg <= {`HISK_EV_W{1'b0}};
        end else if (clkEn) begin
            if (selCw1 && p4Rise) begin
                ctlWord1_reg <= accS;
            end
            if (selCw2 && p4Rise) begin
                ctlWord2_reg <= accS;
            end
            // Buffer: power clear, then clear, then host write, then line
            if (pclrS || (selBuf && p2Rise)) begin
                charBuf_reg <= {CHAR_W{1'b0}}; // see [RQ13]
            end else if (selBuf && p4Rise) begin
                charBuf_reg <= accChar; // see [RQ13]
            end else if (charXferStrobe && !charXferToLine) begin
                charBuf_reg <= lineCharIn;
            end
            // Service flag lives one cycle, long enough to set its target
            charServiceFlag_reg <= charXferStrobe; // see [RQ4]
            if (charXferStrobe) begin
                serviceToLine_reg <= charXferToLine;
            end
            // A new character beats a clear issued in the same cycle
            if (evSet[`HISK_EV_XMIT]) begin
                xmitIrqFlag_reg <= 1'b1; // see [RQ5]
            end else if (pclrS || (selIrq && p2Rise)) begin
                xmitIrqFlag_reg <= 1'b0; // see [RQ8] see [RQ14]
            end
            if (evSet[`HISK_EV_RECV]) begin
                recvIrqFlag_reg <= 1'b1; // see [RQ5]
            end else if (pclrS || (selIrq && p4Rise)) begin
                recvIrqFlag_reg <= 1'b0; // see [RQ8] see [RQ14]
            end
            // Status is sticky, a read clears it, a new event wins
            if (busRd && wb_adr_i == `HISK_OFS_STATUS) begin
                status_reg <= evSet;
            end else begin
                status_reg <= status_reg | evSet;
            end
        end
    end

    // Registered pin drivers
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hostAccumInN <= {WORD_W{1'b1}};
            hostAccumOe <= 1'b0;
            skipLine <= 1'b0;
            irqLine <= 1'b0;
            wbIrq <= 1'b0;
            bufCharOut <= {CHAR_W{1'b0}};
        end else if (clkEn) begin
            // Grounded-emitter style: a one pulls the host line low
            hostAccumInN <= ~extAccumBus; // see [RQ10]
            hostAccumOe <= extBusGateEnable; // see [RQ10]
            skipLine <= skipNext;
            // Enabling is the host's business; the request is raw
            irqLine <= xmitIrqFlag_reg || recvIrqFlag_reg; // see [RQ6]
            wbIrq <= |(status_reg & mask_reg);
            bufCharOut <= charBuf_reg;
        end
    end

endmodule // hisk_port

//--- verification/hisk_host_model.sv
// Host side of the I/O bus: runs one transfer instruction at a time.
// Assumes the port answers within four clocks of a pin change.
`timescale 1ns/1ps
module hisk_host_model (
    // Clock
    input wire sys_clk,
    // Host pins
    output reg [11:0] memBuf,
    output reg ioTransferInstr,
    output reg ioPulseOne,
    output reg ioPulseTwo,
    output reg ioPulseFour,
    output reg [11:0] hostAccumOut,
    input wire [11:0] hostAccumInN,
    input wire hostAccumOe,
    input wire skipLine,
    input wire irqLine,
    // Interrupt system
    input wire intEnable,
    output wire intTaken
);
    assign intTaken = irqLine & intEnable;
    initial begin
        {memBuf, ioTransferInstr, hostAccumOut} = 25'h0;
        {ioPulseFour, ioPulseTwo, ioPulseOne} = 3'h0;
    end
    // Accumulator input reads zero where nobody drives it
    task io_transfer_instr(input [5:0] dev, input [2:0] pul, input [11:0] acc,
        output sk, output [11:0] got);
        begin
            @(posedge sys_clk);
            {memBuf, ioTransferInstr} <= {3'h6, dev, pul, 1'b1};
            hostAccumOut <= acc;
            repeat (2) @(posedge sys_clk);
            {ioPulseFour, ioPulseTwo, ioPulseOne} <= pul;
            repeat (5) @(posedge sys_clk);
            sk = skipLine;
            got = hostAccumOe ? ~hostAccumInN : 12'h000;
            {ioPulseFour, ioPulseTwo, ioPulseOne} <= 3'h0;
            repeat (6) @(posedge sys_clk);
            // Released lines show a changed value, not the last one
            {memBuf, ioTransferInstr} <= {~memBuf, 1'b0};
            hostAccumOut <= ~acc;
        end
    endtask
endmodule // hisk_host_model

//--- verification/hisk_port_asserts.sv
// Checker for hisk_port: bus answer, flags, skip and accumulator drive.
// Assumes the host holds its pins steady for several clocks.
`timescale 1ns/1ps
module hisk_port_asserts #(parameter WORD_W = 12, parameter CHAR_W = 8) (
    // Clock and control
    input wire sys_clk,
    input wire reset,
    input wire clkEn,
    // Bus and line side
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire charXferStrobe,
    // Host pins and character buffer output
    input wire hostPowerClear,
    input wire ioTransferInstr,
    input wire ioPulseOne,
    input wire ioPulseTwo,
    input wire ioPulseFour,
    input wire extGateReq,
    input wire [WORD_W-1:0] extAccumIn,
    input wire [WORD_W-1:0] hostAccumInN,
    input wire hostAccumOe,
    input wire skipLine,
    input wire irqLine,
    input wire [CHAR_W-1:0] bufCharOut
);
    reg [2:0] quietCnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // A flag may only drop some clocks after a clearing pulse
    always @(posedge sys_clk or posedge reset) begin
        if (reset)
            quietCnt <= 3'h0;
        else if (ioPulseTwo || ioPulseFour || hostPowerClear)
            quietCnt <= 3'h0;
        else if (quietCnt != 3'h7)
            quietCnt <= quietCnt + 3'h1;
    end
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_ack_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("no ack");
    property p_irq_set;
        charXferStrobe && clkEn && quietCnt == 3'h7 |-> ##[1:4] irqLine;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("no irq");
    property p_irq_hold; irqLine && quietCnt > 3'h4 |=> irqLine; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
    property p_skip_cause;
        $rose(skipLine) |-> $past(ioPulseOne, 2) && $past(ioTransferInstr, 2);
    endproperty
    a_skip_cause: assert property (p_skip_cause) else $error("skip");
    property p_gate;
        $past(extGateReq, 2) && $past(extGateReq, 4)
        && $past(extAccumIn, 2) == $past(extAccumIn, 4)
        |-> hostAccumOe &&
        (~hostAccumInN & $past(extAccumIn, 3)) == $past(extAccumIn, 3);
    endproperty
    a_gate: assert property (p_gate) else $error("ext bus");
    property p_idle; !hostAccumOe |-> &hostAccumInN; endproperty
    a_idle: assert property (p_idle) else $error("idle bus");
    property p_pclr;
        $past(hostPowerClear, 3) && $past(hostPowerClear, 4)
        |-> !irqLine && bufCharOut == '0;
    endproperty
    a_pclr: assert property (p_pclr) else $error("power clear");
    c_irq: cover property (irqLine);
    c_skip: cover property (skipLine);
    c_gate: cover property (hostAccumOe && extGateReq);
endmodule // hisk_port_asserts

bind hisk_port hisk_port_asserts #(.WORD_W(WORD_W), .CHAR_W(CHAR_W)) u_chk (
    .sys_clk, .reset, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .charXferStrobe, .hostPowerClear, .ioTransferInstr, .ioPulseOne,
    .ioPulseTwo, .ioPulseFour, .extGateReq, .extAccumIn, .hostAccumInN,
    .hostAccumOe, .skipLine, .irqLine, .bufCharOut);

//--- verification/hisk_port_tb_top.sv
// Self-checking bench for hisk_port with a host model on the I/O bus.
// Assumes the checker is bound in and the host model compiled first.
`timescale 1ns/1ps
`define CHK(g, e) chk(g, e)
module hisk_port_tb_top;
    reg sys_clk, reset = 1'b1, clkEn = 1'b1, wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0, wb_we_i = 1'b0, hostPowerClear = 1'b0;
    reg extGateReq = 1'b0, charXferStrobe = 1'b0, charXferToLine = 1'b0;
    reg [7:0] wb_adr_i = 8'h00, lineCharIn = 8'h00;
    reg [3:0] wb_sel_i = 4'hf, g;
    reg [31:0] wb_dat_i = 32'h0, r;
    reg [11:0] extAccumIn = 12'h000, a, b, got;
    reg sk;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, wbIrq, ioTransferInstr, ioPulseOne, ioPulseTwo;
    wire ioPulseFour, skipLine, irqLine, hostAccumOe, intTaken;
    wire [11:0] memBuf, hostAccumOut, hostAccumInN;
    wire [7:0] bufCharOut;
    integer num_errors = 0, compares = 0, d, seed;
    hisk_port u_hisk_port (.sys_clk, .reset, .clkEn, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .wbIrq, .memBuf, .ioTransferInstr, .ioPulseOne, .ioPulseTwo,
        .ioPulseFour, .hostPowerClear, .hostAccumOut, .hostAccumInN,
        .hostAccumOe, .skipLine, .irqLine, .extAccumIn, .extGateReq,
        .charXferStrobe, .charXferToLine, .lineCharIn, .bufCharOut);
    hisk_host_model u_hisk_host_model (.sys_clk, .memBuf, .ioTransferInstr,
        .ioPulseOne, .ioPulseTwo, .ioPulseFour, .hostAccumOut, .hostAccumInN,
        .hostAccumOe, .skipLine, .irqLine, .intEnable(1'b1), .intTaken);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task chk(input [31:0] gv, input [31:0] ev);
        begin
            compares = compares + 1;
            if (gv !== ev) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: %h vs %h", $time, gv, ev);
            end
        end
    endtask
    task test_done;
        begin
            $display("errors %0d compares %0d", num_errors, compares);
            if (num_errors == 0 && compares > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task wbc(input w, input [7:0] adr, input [31:0] dat);
        integer n;
        begin
            @(posedge sys_clk);
            {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w,
                adr, dat};
            n = 0;
            // Look at ack between edges, act on the edge that samples it
            @(negedge sys_clk);
            while (wb_ack_o !== 1'b1 && n < 20) begin
                n = n + 1;
                @(negedge sys_clk);
            end
            if (n == 20)
                num_errors = num_errors + 1;
            r = wb_dat_o;
            @(posedge sys_clk);
            {wb_cyc_i, wb_stb_i} <= 2'h0;
        end
    endtask
    task xfer(input dir, input [7:0] c);
        begin
            @(posedge sys_clk);
            {charXferStrobe, charXferToLine, lineCharIn} <= {1'b1, dir, c};
            @(posedge sys_clk);
            charXferStrobe <= 1'b0;
            repeat (6) @(posedge sys_clk);
        end
    endtask
    function maskSkip(input [11:0] acc, input tx);
        maskSkip = tx ? acc[0] : acc[1];
    endfunction
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors = num_errors + 1;
        test_done;
    end
    initial begin
        seed = $urandom(82448);
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        wbc(1'b0, 8'h00, 0);
        `CHK(r, 32'h8);
        wbc(1'b0, 8'h3c, 0);
        `CHK(r, 32'h0);
        wbc(1'b1, 8'h08, 32'h3);
        $display("test registers done");
        for (d = 0; d < 2; d = d + 1) begin
            g = d ? $urandom : 4'h8;
            wbc(1'b1, 8'h00, {28'h0, g});
            a = $urandom;
            xfer(d[0], a[7:0]);
            `CHK(wbIrq, 1'b1);
            wbc(1'b0, 8'h0c, 0);
            `CHK(r[1:0], d ? 2'h1 : 2'h2);
            if (d == 0)
                `CHK(bufCharOut, a[7:0]);
            u_hisk_host_model.io_transfer_instr({g, 2'h2}, 3'h1, 12'h0, sk, got);
            `CHK(sk, 1'b1);
            u_hisk_host_model.io_transfer_instr({~g, 2'h2}, 3'h1, 12'h0, sk, got);
            `CHK(sk, 1'b0);
            b = $urandom;
            u_hisk_host_model.io_transfer_instr({g, 2'h0}, 3'h1, b, sk, got);
            `CHK(sk, maskSkip(b, d[0]));
            wbc(1'b0, 8'h04, 0);
            `CHK(r[1:0], d ? 2'h1 : 2'h2);
            wbc(1'b0, 8'h04, 0);
            repeat (2) @(posedge sys_clk);
            `CHK(wbIrq, 1'b0);
            `CHK(irqLine, 1'b1);
            `CHK(intTaken, 1'b1);
            u_hisk_host_model.io_transfer_instr({g, 2'h2}, d ? 3'h2 : 3'h4, 0, sk, got);
            `CHK(irqLine, 1'b0);
            $display("test flag %0d done", d);
        end
        a = $urandom;
        u_hisk_host_model.io_transfer_instr({g, 2'h3}, 3'h4, a, sk, got);
        `CHK(bufCharOut, a[7:0]);
        b = $urandom;
        extAccumIn <= b;
        extGateReq <= 1'b1;
        u_hisk_host_model.io_transfer_instr({g, 2'h3}, 3'h1, 12'h0, sk, got);
        `CHK(got, b | {4'h0, a[7:0]});
        extGateReq <= 1'b0;
        u_hisk_host_model.io_transfer_instr({g, 2'h3}, 3'h2, 12'h0, sk, got);
        `CHK(bufCharOut, 8'h00);
        u_hisk_host_model.io_transfer_instr({g, 2'h0}, 3'h4, a, sk, got);
        u_hisk_host_model.io_transfer_instr({g, 2'h1}, 3'h4, b, sk, got);
        wbc(1'b0, 8'h10, 0);
        `CHK(r[11:0], a);
        u_hisk_host_model.io_transfer_instr({g, 2'h1}, 3'h2, 12'h0, sk, got);
        `CHK(got, b);
        $display("test buffer done");
        xfer(1'b0, 8'h5a);
        hostPowerClear <= 1'b1;
        repeat (5) @(posedge sys_clk);
        `CHK(irqLine, 1'b0);
        `CHK(bufCharOut, 8'h00);
        hostPowerClear <= 1'b0;
        $display("test power clear done");
        test_done;
    end
endmodule // hisk_port_tb_top
